// ===== logic/dram_ctrl_end.sv
`timescale 1ns/1ps
module dram_ctrl_end
  import dram_pkg::*;
#(
  parameter int HALF_CYC = LINK_HALF_CYC
) (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  dram_link_if.ctrl LINK,
  input wire logic CMD_VALID,
  output logic CMD_READY,
  input wire cmd_t CMD_OP,
  input wire logic [BANK_W-1:0] CMD_BA,
  input wire logic [ROW_W-1:0] CMD_ADDR,
  output logic CMD_ERR,
  input wire logic ERR_CLR,
  output logic [DQ_W-1:0] RD_DATA,
  output logic RD_VALID
);
  localparam int DIV_W = 8;

  if (HALF_CYC < 2 || HALF_CYC > 127) begin : g_half_chk
    $error("link half period out of range");
  end

  typedef enum logic {ST_IDLE = 1'b0, ST_PEND = 1'b1} cst_t;

  cst_t st_reg, st_next;
  logic [DIV_W-1:0] div_reg, div_next;
  logic lck_reg, lck_next, rdy_reg, rdy_next, err_reg, err_next;
  cmd_t op_reg, op_next, pop_reg, pop_next;
  logic [BANK_W-1:0] ba_reg, ba_next, pba_reg, pba_next;
  logic [ROW_W-1:0] ad_reg, ad_next, pad_reg, pad_next;
  logic [NUM_BANKS-1:0] open_reg, open_next, rpm_reg, rpm_next;
  logic [3:0] gap_reg, gap_next, rp_reg, rp_next;
  logic tick, issue, drop;

  always_comb begin
    st_next = st_reg;
    rdy_next = rdy_reg;
    op_next = op_reg;
    ba_next = ba_reg;
    ad_next = ad_reg;
    pop_next = pop_reg;
    pba_next = pba_reg;
    pad_next = pad_reg;
    open_next = open_reg;
    rpm_next = rpm_reg;
    gap_next = gap_reg;
    rp_next = rp_reg;
    issue = 1'b0;
    drop = 1'b0;
    // ready whenever nothing is pending, also first edge after reset
    if (st_reg == ST_IDLE) begin
      rdy_next = 1'b1;
    end
    div_next = (div_reg == DIV_W'(2 * HALF_CYC - 1)) ? '0 : div_reg + 1'b1;
    lck_next = (div_next < DIV_W'(HALF_CYC));
    tick = (div_reg == DIV_W'(HALF_CYC - 1));
    if (tick) begin
      op_next = CMD_NOP;
      if (gap_reg != 4'h0) begin
        gap_next = gap_reg - 4'h1;
      end
      if (rp_reg != 4'h0) begin
        rp_next = rp_reg - 4'h1;
      end else begin
        rpm_next = '0;
      end
      if (st_reg == ST_PEND) begin
        unique case (pop_reg)
          CMD_ACT: begin
            if (open_reg[pba_reg]) begin
              drop = 1'b1;
            end else if (!(rpm_reg[pba_reg] && rp_reg != 4'h0)) begin
              issue = 1'b1;
              open_next[pba_reg] = 1'b1;
            end
          end
          CMD_PRE: begin
            issue = 1'b1;
            if (pad_reg[AP_BIT]) begin
              rpm_next = {NUM_BANKS{1'b1}};
              open_next = '0;
            end else begin
              rpm_next = rpm_reg;
              rpm_next[pba_reg] = 1'b1;
              open_next[pba_reg] = 1'b0;
            end
            rp_next = 4'(RP_LINK_CYC);
          end
          CMD_RD, CMD_WR: begin
            if (!open_reg[pba_reg]) begin
              drop = 1'b1;
            end else if (gap_reg == 4'h0) begin
              issue = 1'b1;
              gap_next = 4'(COL_GAP - 1);
              if (pad_reg[AP_BIT]) begin
                open_next[pba_reg] = 1'b0;
                rpm_next = rpm_reg;
                rpm_next[pba_reg] = 1'b1;
                rp_next = 4'(RP_LINK_CYC + COL_GAP);
              end
            end
          end
          default: issue = 1'b1;
        endcase
        if (issue) begin
          op_next = pop_reg;
          ba_next = pba_reg;
          ad_next = pad_reg;
        end
        if (issue || drop) begin
          st_next = ST_IDLE;
          rdy_next = 1'b1;
        end
      end
    end else if (st_reg == ST_IDLE && CMD_VALID && rdy_reg) begin
      pop_next = CMD_OP;
      pba_next = CMD_BA;
      pad_next = CMD_ADDR;
      st_next = ST_PEND;
      rdy_next = 1'b0;
    end
    err_next = (err_reg & ~ERR_CLR) | drop;
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      st_reg <= ST_IDLE;
      div_reg <= DIV_W'(2 * HALF_CYC - 1);
      lck_reg <= 1'b0;
      rdy_reg <= 1'b0;
      err_reg <= 1'b0;
      op_reg <= CMD_NOP;
      ba_reg <= '0;
      ad_reg <= '0;
      pop_reg <= CMD_NOP;
      pba_reg <= '0;
      pad_reg <= '0;
      open_reg <= '0;
      rpm_reg <= '0;
      gap_reg <= 4'h0;
      rp_reg <= 4'h0;
    end else begin
      st_reg <= st_next;
      div_reg <= div_next;
      lck_reg <= lck_next;
      rdy_reg <= rdy_next;
      err_reg <= err_next;
      op_reg <= op_next;
      ba_reg <= ba_next;
      ad_reg <= ad_next;
      pop_reg <= pop_next;
      pba_reg <= pba_next;
      pad_reg <= pad_next;
      open_reg <= open_next;
      rpm_reg <= rpm_next;
      gap_reg <= gap_next;
      rp_reg <= rp_next;
    end
  end

  // read capture: strobe and data synced, beat on each strobe edge
  logic dqs_m_reg, dqs_s_reg, dqs_d_reg;
  logic [DQ_W-1:0] dq_m_reg, dq_s_reg, rdd_reg;
  logic rdv_reg;

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      dqs_m_reg <= 1'b0;
      dqs_s_reg <= 1'b0;
      dqs_d_reg <= 1'b0;
      dq_m_reg <= '0;
      dq_s_reg <= '0;
      rdd_reg <= '0;
      rdv_reg <= 1'b0;
    end else begin
      dqs_m_reg <= LINK.dqs;
      dqs_s_reg <= dqs_m_reg;
      dqs_d_reg <= dqs_s_reg;
      dq_m_reg <= LINK.dq_bus;
      dq_s_reg <= dq_m_reg;
      rdv_reg <= dqs_s_reg ^ dqs_d_reg;
      rdd_reg <= dq_s_reg;
    end
  end

  assign LINK.lck = lck_reg;
  assign LINK.cmd = op_reg;
  assign LINK.ba = ba_reg;
  assign LINK.addr = ad_reg;
  assign CMD_READY = rdy_reg;
  assign CMD_ERR = err_reg;
  assign RD_DATA = rdd_reg;
  assign RD_VALID = rdv_reg;
endmodule

// ===== logic/dram_link_if.sv
`timescale 1ns/1ps
interface dram_link_if;
  import dram_pkg::*;
  logic lck;
  cmd_t cmd;
  logic [BANK_W-1:0] ba;
  logic [ROW_W-1:0] addr;
  logic [DQ_W-1:0] dq_drv;
  logic dq_oe;
  logic dqs;
  logic [DQ_W-1:0] dq_bus;

  // resolved data wire, reads low while undriven
  assign dq_bus = dq_oe ? dq_drv : '0;

  modport ctrl(
    output lck,
    output cmd,
    output ba,
    output addr,
    input dq_bus,
    input dqs
  );
  modport mem(
    input lck,
    input cmd,
    input ba,
    input addr,
    output dq_drv,
    output dq_oe,
    output dqs
  );
endinterface

// ===== logic/dram_mem_end.sv
`timescale 1ns/1ps
module dram_mem_end
  import dram_pkg::*;
#(
  parameter int PIPE_DEPTH = 32
) (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  dram_link_if.mem LINK,
  input wire logic ERR_CLR,
  output logic [NUM_BANKS-1:0] BANK_OPEN,
  output logic ERR_FLAG
);
  localparam int CW = 3 + BANK_W + ROW_W;

  // every latency tap index must exist, including rl - 1 at rl zero
  if (PIPE_DEPTH < (1 << RL_W)) begin : g_depth_chk
    $error("pipe too shallow for read latency");
  end

  // two-flop sync of link clock and command lines
  logic lck_m_reg, lck_s_reg, lck_d_reg;
  logic [CW-1:0] cmd_m_reg, cmd_s_reg;

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      lck_m_reg <= 1'b0;
      lck_s_reg <= 1'b0;
      lck_d_reg <= 1'b0;
      cmd_m_reg <= '0;
      cmd_s_reg <= '0;
    end else begin
      lck_m_reg <= LINK.lck;
      lck_s_reg <= lck_m_reg;
      lck_d_reg <= lck_s_reg;
      cmd_m_reg <= {LINK.cmd, LINK.ba, LINK.addr};
      cmd_s_reg <= cmd_m_reg;
    end
  end

  logic rise, edge_any;
  cmd_t c_op;
  logic [BANK_W-1:0] c_ba;
  logic [ROW_W-1:0] c_addr;

  assign rise = lck_s_reg & ~lck_d_reg;
  assign edge_any = lck_s_reg ^ lck_d_reg;
  assign c_op = cmd_t'(cmd_s_reg[CW-1 -: 3]);
  assign c_ba = cmd_s_reg[ROW_W +: BANK_W];
  assign c_addr = cmd_s_reg[ROW_W-1:0];

  // bank, mode, pipe and burst state
  logic [NUM_BANKS-1:0] open_reg, open_next;
  logic [ROW_W-1:0] row_reg [NUM_BANKS];
  logic [ROW_W-1:0] row_next [NUM_BANKS];
  logic [1:0] blmode_reg, blmode_next;
  logic [LAT_W-1:0] cl_reg, cl_next, al_reg, al_next;
  rd_ent_t pipe_reg [PIPE_DEPTH];
  rd_ent_t pipe_next [PIPE_DEPTH];
  logic [3:0] beats_reg, beats_next, idx_reg, idx_next;
  logic [DQ_W-1:0] seed_reg, seed_next, dq_reg, dq_next;
  logic oe_reg, oe_next, dqs_reg, dqs_next;
  logic err_reg, err_next;
  logic err_set;
  logic [RL_W-1:0] rl;
  rd_ent_t tap;
  logic [COL_W-1:0] col;

  always_comb begin
    open_next = open_reg;
    row_next = row_reg;
    blmode_next = blmode_reg;
    cl_next = cl_reg;
    al_next = al_reg;
    pipe_next = pipe_reg;
    beats_next = beats_reg;
    idx_next = idx_reg;
    seed_next = seed_reg;
    dq_next = dq_reg;
    oe_next = oe_reg;
    dqs_next = dqs_reg;
    err_set = 1'b0;
    rl = RL_W'(al_reg) + RL_W'(cl_reg);
    tap = pipe_reg[RL_W'(rl - RL_W'(1))];
    col = c_addr[COL_W-1:0];
    if (rise) begin
      for (int i = PIPE_DEPTH - 1; i > 0; i--) begin
        pipe_next[i] = pipe_reg[i-1];
      end
      pipe_next[0] = '0;
      unique case (c_op)
        CMD_ACT: begin
          if (!open_reg[c_ba]) begin
            open_next[c_ba] = 1'b1;
            row_next[c_ba] = c_addr;
          end else if (row_reg[c_ba] != c_addr) begin
            err_set = 1'b1;
          end
        end
        CMD_PRE: begin
          if (c_addr[AP_BIT]) begin
            open_next = '0;
          end else begin
            open_next[c_ba] = 1'b0;
          end
        end
        CMD_RD, CMD_WR: begin
          if (!open_reg[c_ba]) begin
            err_set = 1'b1;
          end else begin
            if (c_op == CMD_RD) begin
              pipe_next[0].v = 1'b1;
              pipe_next[0].bl8 = is_bl8(blmode_reg, c_addr[BC_BIT]);
              pipe_next[0].seed =
                DQ_W'({row_reg[c_ba][5:0], col});
            end
            if (c_addr[AP_BIT]) begin
              open_next[c_ba] = 1'b0;
            end
          end
        end
        CMD_MRS: begin
          blmode_next = c_addr[BL_LSB +: 2];
          cl_next = c_addr[CL_LSB +: LAT_W];
          al_next = c_addr[AL_LSB +: LAT_W];
        end
        default: begin
        end
      endcase
    end
    // one beat on every link clock edge
    if (rise && tap.v) begin
      beats_next = (tap.bl8 ? BEATS_BL8 : BEATS_BC4) - 4'h1;
      idx_next = 4'h1;
      seed_next = tap.seed;
      dq_next = tap.seed;
      dqs_next = ~dqs_reg;
      oe_next = 1'b1;
    end else if (edge_any) begin
      if (beats_reg != 4'h0) begin
        beats_next = beats_reg - 4'h1;
        idx_next = idx_reg + 4'h1;
        dq_next = seed_reg + DQ_W'(idx_reg);
        dqs_next = ~dqs_reg;
      end else begin
        oe_next = 1'b0;
      end
    end
    err_next = (err_reg & ~ERR_CLR) | err_set;
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      open_reg <= '0;
      row_reg <= '{default: '0};
      blmode_reg <= BL_RESET;
      cl_reg <= CL_RESET;
      al_reg <= AL_RESET;
      pipe_reg <= '{default: '0};
      beats_reg <= 4'h0;
      idx_reg <= 4'h0;
      seed_reg <= '0;
      dq_reg <= '0;
      oe_reg <= 1'b0;
      dqs_reg <= 1'b0;
      err_reg <= 1'b0;
    end else begin
      open_reg <= open_next;
      row_reg <= row_next;
      blmode_reg <= blmode_next;
      cl_reg <= cl_next;
      al_reg <= al_next;
      pipe_reg <= pipe_next;
      beats_reg <= beats_next;
      idx_reg <= idx_next;
      seed_reg <= seed_next;
      dq_reg <= dq_next;
      oe_reg <= oe_next;
      dqs_reg <= dqs_next;
      err_reg <= err_next;
    end
  end

  assign LINK.dq_drv = dq_reg;
  assign LINK.dq_oe = oe_reg;
  assign LINK.dqs = dqs_reg;
  assign BANK_OPEN = open_reg;
  assign ERR_FLAG = err_reg;
endmodule

// ===== logic/dram_pkg.sv
// How it works
// - activate picks bank by bank bits, row by address
// - opened row stays open until its bank precharges
// - controller drops an activate to an open bank and flags error
// - precharge closes one bank or all banks
// - controller waits precharge period before reactivating
// - auto precharge runs while other banks transfer
// - precharged bank idle; activate before read/write
// - precharge to idle bank accepted, restarts period
// - on-the-fly bit twelve picks four or eight beats
// - bit twelve never used as column bit
// - auto precharge chosen per command, independent
// - eight beats when fixed-eight or on-the-fly high
// - fixed chop mode gives four beats
// - data starts additive plus column latency later
package dram_pkg;
  localparam int NUM_BANKS = 8;
  localparam int BANK_W = 3;
  localparam int ROW_W = 14;
  localparam int DQ_W = 16;
  localparam int COL_W = 10;
  localparam int SYS_PERIOD_NS = 100;
  localparam int LINK_PERIOD_NS = 800;
  localparam int LINK_HALF_CYC = LINK_PERIOD_NS / (2 * SYS_PERIOD_NS);
  localparam int T_RP_NS = 15;
  localparam int RP_RAW = (T_RP_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
  localparam int RP_LINK_CYC = (RP_RAW < 1) ? 1 : RP_RAW;
  localparam int COL_GAP = 4;
  localparam logic [3:0] BEATS_BL8 = 4'h8;
  localparam logic [3:0] BEATS_BC4 = 4'h4;
  localparam int AP_BIT = 10;
  localparam int BC_BIT = 12;
  localparam int BL_LSB = 0;
  localparam int CL_LSB = 4;
  localparam int AL_LSB = 8;
  localparam int LAT_W = 4;
  localparam int RL_W = 5;
  localparam int RL_MAX = 30;
  localparam logic [1:0] BL_FIXED8 = 2'h0;
  localparam logic [1:0] BL_OTF = 2'h1;
  localparam logic [1:0] BL_FIXED4 = 2'h2;
  localparam logic [1:0] BL_RESET = 2'h0;
  localparam logic [3:0] CL_RESET = 4'h6;
  localparam logic [3:0] AL_RESET = 4'h0;

  typedef enum logic [2:0] {
    CMD_NOP = 3'h0,
    CMD_ACT = 3'h1,
    CMD_PRE = 3'h2,
    CMD_RD = 3'h3,
    CMD_WR = 3'h4,
    CMD_MRS = 3'h5
  } cmd_t;

  typedef struct packed {
    logic v;
    logic bl8;
    logic [DQ_W-1:0] seed;
  } rd_ent_t;

  // burst length decode from mode field and bit twelve
  function automatic logic is_bl8(logic [1:0] mode, logic a12);
    return (mode == BL_FIXED8) || (mode == BL_OTF && a12);
  endfunction
endpackage

// ===== sim/dram_link_monitor.sv
`timescale 1ns/1ps
module dram_link_monitor
  import dram_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic lck,
  input wire cmd_t cmd,
  input wire logic [BANK_W-1:0] ba,
  input wire logic [ROW_W-1:0] addr,
  input wire logic [DQ_W-1:0] dq_drv,
  input wire logic dq_oe,
  input wire logic dqs
);
  logic [4:0] beat_reg;

  default clocking @(posedge CLK_SYS);
  endclocking
  default disable iff (!RST_N);

  // strobe toggles within one driven run
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N || !dq_oe) begin
      beat_reg <= 5'h0;
    end else if ($changed(dqs)) begin
      beat_reg <= beat_reg + 5'h1;
    end
  end

  sequence quiet_s;
    !$changed(dqs) [*3];
  endsequence
  sequence high_s;
    lck [*3] ##1 !lck;
  endsequence

  cmd_on_fall_a: assert property (
    $changed({cmd, ba, addr}) |-> $fell(lck))
    else $error("command moved off a clock fall");
  cmd_hold_a: assert property (
    $changed(cmd) && cmd != CMD_NOP |=> $stable(cmd) [*7])
    else $error("command held too short");
  lck_half_a: assert property ($rose(lck) |=> high_s)
    else $error("link clock half period wrong");
  strobe_oe_a: assert property ($changed(dqs) |-> dq_oe)
    else $error("strobe moved while undriven");
  data_strobe_a: assert property (
    dq_oe && $changed(dq_drv) |-> $changed(dqs))
    else $error("data moved without strobe");
  beat_hold_a: assert property ($changed(dqs) |=> quiet_s)
    else $error("beat shorter than half period");
  oe_start_a: assert property ($rose(dq_oe) |-> $changed(dqs))
    else $error("drive began without a beat");
  burst_len_a: assert property (
    $fell(dq_oe) |-> beat_reg[1:0] == 2'h0 && beat_reg != 5'h0)
    else $error("burst not a whole four beats");
endmodule

// ===== sim/test_dram_row_open_close_read_burst.sv
`timescale 1ns/1ps
module test_dram_row_open_close_read_burst
  import dram_pkg::*;
;
  logic clk_sys, rst_n, cmd_valid, cmd_ready, cmd_err, err_clr;
  logic rd_valid, err_flag;
  cmd_t cmd_op;
  logic [BANK_W-1:0] cmd_ba, b, b2;
  logic [ROW_W-1:0] cmd_addr;
  logic [DQ_W-1:0] rd_data;
  logic [NUM_BANKS-1:0] bank_open, exp_open;
  logic [ROW_W-1:0] rows [NUM_BANKS];
  logic [DQ_W-1:0] rdq [$];
  logic [15:0] lfsr;
  logic [1:0] mode;
  int rl, num_errors, total_checks;
  time t_cmd, t_first;

  dram_link_if dram_link_if_i ();
  dram_ctrl_end dram_ctrl_end_i (.CLK_SYS(clk_sys), .RST_N(rst_n),
    .LINK(dram_link_if_i.ctrl), .CMD_VALID(cmd_valid),
    .CMD_READY(cmd_ready), .CMD_OP(cmd_op), .CMD_BA(cmd_ba),
    .CMD_ADDR(cmd_addr), .CMD_ERR(cmd_err), .ERR_CLR(err_clr),
    .RD_DATA(rd_data), .RD_VALID(rd_valid));
  dram_mem_end dram_mem_end_i (.CLK_SYS(clk_sys), .RST_N(rst_n),
    .LINK(dram_link_if_i.mem), .ERR_CLR(err_clr),
    .BANK_OPEN(bank_open), .ERR_FLAG(err_flag));
  dram_link_monitor dram_link_monitor_i (.CLK_SYS(clk_sys),
    .RST_N(rst_n), .lck(dram_link_if_i.lck), .cmd(dram_link_if_i.cmd),
    .ba(dram_link_if_i.ba), .addr(dram_link_if_i.addr),
    .dq_drv(dram_link_if_i.dq_drv), .dq_oe(dram_link_if_i.dq_oe),
    .dqs(dram_link_if_i.dqs));

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // collect read beats
  always @(posedge clk_sys) begin
    if (rd_valid === 1'b1) begin
      if (rdq.size() == 0) t_first = $time;
      rdq.push_back(rd_data);
    end
  end

  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic logic bl8_of(input logic [1:0] m, input logic a12);
    return m == 2'h0 || (m == 2'h1 && a12);
  endfunction

  task automatic complete_run();
    if (num_errors == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  task automatic wait_lvl(input logic lvl);
    for (int i = 0; i < 300 && cmd_ready !== lvl; i++) @(posedge clk_sys);
    if (cmd_ready !== lvl) begin
      num_errors++;
      complete_run();
    end
  endtask

  task automatic issue(input cmd_t op, input logic [2:0] bk,
      input logic [13:0] a);
    @(negedge clk_sys);
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_ba = bk;
    cmd_addr = a;
    wait_lvl(1'b0);
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    wait_lvl(1'b1);
    t_cmd = $time;
    repeat (12) @(posedge clk_sys);
  endtask

  task automatic err_chk(input logic e);
    chk(cmd_err, e);
    chk(err_flag, 1'b0);
    @(negedge clk_sys);
    err_clr = 1'b1;
    @(negedge clk_sys);
    err_clr = 1'b0;
    chk(cmd_err, 1'b0);
  endtask

  task automatic rd(input logic [2:0] bk, input logic [13:0] a);
    int n;
    logic [15:0] seed;
    n = bl8_of(mode, a[12]) ? 8 : 4;
    seed = {rows[bk][5:0], a[9:0]};
    rdq.delete();
    issue(CMD_RD, bk, a);
    for (int i = 0; i < 400 && rdq.size() < n; i++) @(posedge clk_sys);
    repeat (40) @(posedge clk_sys);
    chk(rdq.size(), n);
    chk((t_first - t_cmd) / 100 > 8 * rl, 1'b1);
    chk((t_first - t_cmd) / 100 < 8 * rl + 16, 1'b1);
    for (int k = 0; k < rdq.size(); k++) chk(rdq[k], seed + k);
    if (a[10]) exp_open[bk] = 1'b0;
    chk(bank_open, exp_open);
  endtask

  initial begin
    rst_n = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = CMD_NOP;
    cmd_ba = 3'h0;
    cmd_addr = 14'h0;
    err_clr = 1'b0;
    exp_open = 8'h0;
    lfsr = 16'h8CBA;
    repeat (3) @(negedge clk_sys);
    rst_n = 1'b1;
    for (int m = 0; m < 4; m++) begin
      mode = m[1:0];
      rl = m + 5 + m;
      issue(CMD_MRS, 3'h0, {2'h0, m[3:0], m[3:0] + 4'h5, 2'h0, mode});
      lfsr = nxt(lfsr);
      b = lfsr[2:0];
      b2 = b + 3'h1;
      rows[b] = lfsr[13:0];
      rows[b2] = ~lfsr[13:0];
      issue(CMD_ACT, b, rows[b]);
      issue(CMD_ACT, b2, rows[b2]);
      exp_open[b] = 1'b1;
      exp_open[b2] = 1'b1;
      chk(bank_open, exp_open);
      rd(b, {lfsr[13], m[0], lfsr[11], 1'b0, lfsr[9:0]});
      issue(CMD_ACT, b, rows[b] ^ 14'h1);
      err_chk(1'b1);
      rd(b2, {lfsr[15], ~m[0], lfsr[14], 1'b1, ~lfsr[9:0]});
      issue(CMD_RD, b2, 14'h0);
      err_chk(1'b1);
      issue(CMD_PRE, b2, 14'h0);
      err_chk(1'b0);
      issue(CMD_ACT, b2, rows[b2]);
      exp_open[b2] = 1'b1;
      issue(CMD_WR, b, {lfsr[13:11], 1'b1, lfsr[9:0]});
      exp_open[b] = 1'b0;
      chk(bank_open, exp_open);
      issue(CMD_PRE, b, 14'h0);
      exp_open[b] = 1'b0;
      chk(bank_open, exp_open);
      issue(CMD_PRE, 3'h0, 14'h0400);
      exp_open = 8'h0;
      chk(bank_open, exp_open);
    end
    complete_run();
  end
endmodule
